// *** hw/pfm_defs.vh ***
`ifndef PFM_DEFS_VH
`define PFM_DEFS_VH

// register byte offsets on the bus, one aligned word each
`define PFM_OFS_INPUT_SOURCE_SELECT 8'h00
`define PFM_OFS_PORTA_FUNCTION_LOW 8'h04
`define PFM_OFS_PORTA_FUNCTION_HIGH 8'h08
`define PFM_OFS_PORTB_FUNCTION_LOW 8'h0c
`define PFM_OFS_PORTB_FUNCTION_HIGH 8'h10
`define PFM_OFS_PORTC_FUNCTION_LOW 8'h14
`define PFM_OFS_PORTC_FUNCTION_HIGH 8'h18
`define PFM_OFS_PORTD_FUNCTION_LOW 8'h1c
`define PFM_OFS_PORTD_FUNCTION_HIGH 8'h20
`define PFM_OFS_PORTE_FUNCTION_LOW 8'h24
`define PFM_OFS_PORTE_FUNCTION_HIGH 8'h28
`define PFM_OFS_PORTF_FUNCTION_SEL 8'h2c

// register file index; selection registers follow the input source one
`define PFM_NREG 12
`define PFM_IDX_INPUT_SOURCE 4'h0
`define PFM_IDX_PORTD_HIGH 4'h8
`define PFM_IDX_NONE 4'hf

// reset value and writable masks
`define PFM_RST_SEL 8'h00
`define PFM_MASK_FULL 8'hff
`define PFM_MASK_INPUT_SOURCE 8'h7f
`define PFM_MASK_PORTD_HIGH 8'h3f

// input source bit positions
`define PFM_IFS_SERIAL_CLOCK 6
`define PFM_IFS_SERIAL_DATA 5
`define PFM_IFS_UART_RX 4
`define PFM_IFS_CT1_CLOCK 3
`define PFM_IFS_CHIP_SELECT 2
`define PFM_IFS_PT_CAPTURE 1
`define PFM_IFS_ST_CAPTURE 0

// selection codes
`define PFM_CODE_ALT1 2'b01
`define PFM_CODE_ALT2 2'b10
`define PFM_CODE_ALT3 2'b11

// pin numbering: port base plus bit
`define PFM_PA 0
`define PFM_PB 8
`define PFM_PC 16
`define PFM_PD 24
`define PFM_PE 32
`define PFM_PF 40
`define PFM_NPIN 44

// digital peripheral functions driven onto pins
`define PFM_NFN 14
`define PFM_FN_SDO 0
`define PFM_FN_SCS 1
`define PFM_FN_SCK 2
`define PFM_FN_SDA 3
`define PFM_FN_TX 4
`define PFM_FN_RX 5
`define PFM_FN_COMPACT_TIMER0_OUT 6
`define PFM_FN_COMPACT_TIMER0_OUT_INV 7
`define PFM_FN_COMPACT_TIMER1_OUT 8
`define PFM_FN_COMPACT_TIMER1_OUT_INV 9
`define PFM_FN_STP 10
`define PFM_FN_STANDARD_TIMER_OUT_INV 11
`define PFM_FN_PTP 12
`define PFM_FN_PERIODIC_TIMER_OUT_INV 13

`endif

// *** hw/pfm_sync.v ***
module pfm_sync #(
  parameter W = 44
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // raw and filtered levels
  input wire [W-1:0] async_i,
  output wire [W-1:0] level_o
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] level_r;
  wire [W-1:0] level_nxt;

  // a change counts only once stages two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      level_r <= {W{1'b0}};
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule // pfm_sync

// *** hw/pfm_pin_cell.v ***
module pfm_pin_cell (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // selection code and the four candidates
  input wire [1:0] code_i,
  input wire [3:0] opt_out_i,
  input wire [3:0] opt_drv_i,
  input wire [3:0] opt_ana_i,
  // pad side
  output wire pad_out_o,
  output wire pad_oe_n_o,
  output wire pad_analog_o
);

  reg out_r;
  reg oe_n_r;
  reg ana_r;

  // analog functions always release the digital driver
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
      oe_n_r <= 1'b1;
      ana_r <= 1'b0;
    end else begin
      out_r <= opt_out_i[code_i];
      oe_n_r <= ~(opt_drv_i[code_i] & ~opt_ana_i[code_i]);
      ana_r <= opt_ana_i[code_i];
    end
  end

  assign pad_out_o = out_r;
  assign pad_oe_n_o = oe_n_r;
  assign pad_analog_o = ana_r;

endmodule // pfm_pin_cell

// *** hw/pfm_pin_mux.v ***
// How it works
// - serial clock input: PB1, or PF0 when bit6
// - serial data input: PB0, or PF1 when bit5
// - uart receive input: PB3, or PF3 when bit4
// - timer1 clock input: PE5, or PF0 when bit3
// - spi chip select input: PA2, or PA3 when bit2
// - periodic capture input: PB2, or PB4 when bit1
// - standard capture input: PE2, or PE3 when bit0
// - unimplemented bits read zero, ignore writes
// - PA3: chip select 01, low crystal 10
// - PA2: chip select on 01 only
// - PA1: timer0 out 01, bias level 11
// - PA0: spi data out on 01 only
// - PA7 key/segment; PA6 pump cap on 11
// - PA5 timer0 inverse/cap; PA4 data out/crystal
// - PB3 rx/analog; PB2 tx/timer/analog
// - PB1 serial clock/analog; PB0 data/vref/analog
// - PB7..4 keys/analog; PB4 inverse timer 01
// - port C pins: touch keys on 10
// - port D pins: keys 10, segments 11
// - PE3..0 segments, timer outputs, oscillator
// - PE7..4 keys, segments, timer1 outputs
// - PF3..0 segments, timer1, serial, uart
//
// Our own choices: the register addresses and register access over Wishbone.
`include "pfm_defs.vh"

module pfm_pin_mux (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // package pins
  input wire [`PFM_NPIN-1:0] pad_in_i,
  output wire [`PFM_NPIN-1:0] pad_out_o,
  output wire [`PFM_NPIN-1:0] pad_oe_n_o,
  output wire [`PFM_NPIN-1:0] pad_analog_o,
  // port logic
  input wire [`PFM_NPIN-1:0] gpio_out_i,
  input wire [`PFM_NPIN-1:0] gpio_drv_i,
  output wire [`PFM_NPIN-1:0] gpio_in_o,
  // peripheral outputs
  input wire [`PFM_NFN-1:0] fn_out_i,
  input wire [`PFM_NFN-1:0] fn_drv_i,
  // routed peripheral inputs
  output wire serial_clock_in_o,
  output wire serial_data_in_line_o,
  output wire uart_rx_in_o,
  output wire compact_timer1_clock_in_o,
  output wire spi_chip_select_in_o,
  output wire periodic_timer_capture_in_o,
  output wire standard_timer_capture_in_o,
  output wire compact_timer0_clock_in_o,
  output wire external_irq_zero_o,
  output wire external_irq_one_o,
  output wire periodic_timer_clock_in_o,
  output wire standard_timer_clock_in_o,
  // analog function enables
  output wire [23:0] touch_key_inputs_en_o,
  output wire [23:0] lcd_segment_outputs_en_o,
  output wire [7:0] analog_channel_inputs_en_o,
  output wire low_crystal_in_en_o,
  output wire low_crystal_out_en_o,
  output wire high_crystal_in_en_o,
  output wire high_crystal_out_en_o,
  output wire adc_vref_en_o,
  output wire lcd_bias_level_two_en_o,
  output wire lcd_pump_cap_first_en_o,
  output wire lcd_pump_cap_second_en_o
);

  reg [7:0] sel_r [0:`PFM_NREG-1];
  reg ack_r;
  reg [7:0] rdat_r;
  reg [3:0] idx;
  reg [7:0] wmask;
  wire req;
  wire [`PFM_NPIN-1:0] pin_w;
  wire [2*`PFM_NPIN-1:0] cd_w;
  reg [4*`PFM_NPIN-1:0] fo;
  reg [4*`PFM_NPIN-1:0] fd;
  reg [4*`PFM_NPIN-1:0] fa;
  reg [11:0] route_r;
  reg [23:0] key_nxt;
  reg [23:0] seg_nxt;
  reg [7:0] an_nxt;
  reg [23:0] key_r;
  reg [23:0] seg_r;
  reg [7:0] an_r;
  reg [7:0] misc_r;
  integer i;
  integer p;
  integer n;
  genvar g;

  // ---------------- bus slave ----------------
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;

  // unmapped addresses still ack, read zero and drop writes
  always @* begin
    case (wb_adr_i)
      `PFM_OFS_INPUT_SOURCE_SELECT: idx = 4'h0;
      `PFM_OFS_PORTA_FUNCTION_LOW: idx = 4'h1;
      `PFM_OFS_PORTA_FUNCTION_HIGH: idx = 4'h2;
      `PFM_OFS_PORTB_FUNCTION_LOW: idx = 4'h3;
      `PFM_OFS_PORTB_FUNCTION_HIGH: idx = 4'h4;
      `PFM_OFS_PORTC_FUNCTION_LOW: idx = 4'h5;
      `PFM_OFS_PORTC_FUNCTION_HIGH: idx = 4'h6;
      `PFM_OFS_PORTD_FUNCTION_LOW: idx = 4'h7;
      `PFM_OFS_PORTD_FUNCTION_HIGH: idx = 4'h8;
      `PFM_OFS_PORTE_FUNCTION_LOW: idx = 4'h9;
      `PFM_OFS_PORTE_FUNCTION_HIGH: idx = 4'ha;
      `PFM_OFS_PORTF_FUNCTION_SEL: idx = 4'hb;
      default: idx = `PFM_IDX_NONE;
    endcase
    if (idx == `PFM_IDX_INPUT_SOURCE)
      wmask = `PFM_MASK_INPUT_SOURCE;
    else if (idx == `PFM_IDX_PORTD_HIGH)
      wmask = `PFM_MASK_PORTD_HIGH;
    else
      wmask = `PFM_MASK_FULL;
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 8'h00;
      for (i = 0; i < `PFM_NREG; i = i + 1)
        sel_r[i] <= `PFM_RST_SEL;
    end else begin
      ack_r <= req;
      if (req) begin
        rdat_r <= (idx == `PFM_IDX_NONE) ? 8'h00 : sel_r[idx];
        if (wb_we_i && wb_sel_i[0] && idx != `PFM_IDX_NONE)
          sel_r[idx] <= wb_dat_i[7:0] & wmask;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h00_0000, rdat_r};

  // ---------------- pin inputs ----------------
  pfm_sync #(
    .W(`PFM_NPIN)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(pad_in_i),
    .level_o(pin_w)
  );

  assign gpio_in_o = pin_w;

  // relocatable inputs follow the source bits; fixed ones are plain taps
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      route_r <= 12'h000;
    end else begin
      route_r[0] <= sel_r[0][`PFM_IFS_SERIAL_CLOCK] ? pin_w[`PFM_PF+0] : pin_w[`PFM_PB+1];
      route_r[1] <= sel_r[0][`PFM_IFS_SERIAL_DATA] ? pin_w[`PFM_PF+1] : pin_w[`PFM_PB+0];
      route_r[2] <= sel_r[0][`PFM_IFS_UART_RX] ? pin_w[`PFM_PF+3] : pin_w[`PFM_PB+3];
      route_r[3] <= sel_r[0][`PFM_IFS_CT1_CLOCK] ? pin_w[`PFM_PF+0] : pin_w[`PFM_PE+5];
      route_r[4] <= sel_r[0][`PFM_IFS_CHIP_SELECT] ? pin_w[`PFM_PA+3] : pin_w[`PFM_PA+2];
      route_r[5] <= sel_r[0][`PFM_IFS_PT_CAPTURE] ? pin_w[`PFM_PB+4] : pin_w[`PFM_PB+2];
      route_r[6] <= sel_r[0][`PFM_IFS_ST_CAPTURE] ? pin_w[`PFM_PE+3] : pin_w[`PFM_PE+2];
      route_r[7] <= pin_w[`PFM_PA+6];
      route_r[8] <= pin_w[`PFM_PA+6];
      route_r[9] <= pin_w[`PFM_PB+7];
      route_r[10] <= pin_w[`PFM_PB+6];
      route_r[11] <= pin_w[`PFM_PB+5];
    end
  end

  assign serial_clock_in_o = route_r[0];
  assign serial_data_in_line_o = route_r[1];
  assign uart_rx_in_o = route_r[2];
  assign compact_timer1_clock_in_o = route_r[3];
  assign spi_chip_select_in_o = route_r[4];
  assign periodic_timer_capture_in_o = route_r[5];
  assign standard_timer_capture_in_o = route_r[6];
  assign compact_timer0_clock_in_o = route_r[7];
  assign external_irq_zero_o = route_r[8];
  assign external_irq_one_o = route_r[9];
  assign periodic_timer_clock_in_o = route_r[10];
  assign standard_timer_clock_in_o = route_r[11];

  // ---------------- output candidates ----------------
  task automatic dig;
    input integer pin;
    input integer code;
    input o;
    input d;
    begin
      fo[4*pin+code] = o;
      fd[4*pin+code] = d;
    end
  endtask

  task automatic ana;
    input integer pin;
    input integer code;
    begin
      fa[4*pin+code] = 1'b1;
      fd[4*pin+code] = 1'b0;
    end
  endtask

  // every code not named below stays general purpose I/O
  always @* begin
    fo = {4*`PFM_NPIN{1'b0}};
    fd = {4*`PFM_NPIN{1'b0}};
    fa = {4*`PFM_NPIN{1'b0}};
    for (p = 0; p < `PFM_NPIN; p = p + 1) begin
      fo[4*p+:4] = {4{gpio_out_i[p]}};
      fd[4*p+:4] = {4{gpio_drv_i[p]}};
    end
    dig(`PFM_PA+3, 1, fn_out_i[`PFM_FN_SCS], fn_drv_i[`PFM_FN_SCS]);
    ana(`PFM_PA+3, 2);
    dig(`PFM_PA+2, 1, fn_out_i[`PFM_FN_SCS], fn_drv_i[`PFM_FN_SCS]);
    dig(`PFM_PA+1, 1, fn_out_i[`PFM_FN_COMPACT_TIMER0_OUT], fn_drv_i[`PFM_FN_COMPACT_TIMER0_OUT]);
    ana(`PFM_PA+1, 3);
    dig(`PFM_PA+0, 1, fn_out_i[`PFM_FN_SDO], fn_drv_i[`PFM_FN_SDO]);
    ana(`PFM_PA+7, 2);
    ana(`PFM_PA+7, 3);
    ana(`PFM_PA+6, 3);
    dig(`PFM_PA+5, 1, fn_out_i[`PFM_FN_COMPACT_TIMER0_OUT_INV], fn_drv_i[`PFM_FN_COMPACT_TIMER0_OUT_INV]);
    ana(`PFM_PA+5, 3);
    dig(`PFM_PA+4, 1, fn_out_i[`PFM_FN_SDO], fn_drv_i[`PFM_FN_SDO]);
    ana(`PFM_PA+4, 2);
    dig(`PFM_PB+3, 1, fn_out_i[`PFM_FN_RX], fn_drv_i[`PFM_FN_RX]);
    dig(`PFM_PB+2, 1, fn_out_i[`PFM_FN_TX], fn_drv_i[`PFM_FN_TX]);
    dig(`PFM_PB+2, 2, fn_out_i[`PFM_FN_PTP], fn_drv_i[`PFM_FN_PTP]);
    dig(`PFM_PB+1, 1, fn_out_i[`PFM_FN_SCK], fn_drv_i[`PFM_FN_SCK]);
    dig(`PFM_PB+0, 1, fn_out_i[`PFM_FN_SDA], fn_drv_i[`PFM_FN_SDA]);
    ana(`PFM_PB+0, 2);
    for (p = 0; p < 4; p = p + 1)
      ana(`PFM_PB+p, 3);
    dig(`PFM_PB+4, 1, fn_out_i[`PFM_FN_PERIODIC_TIMER_OUT_INV], fn_drv_i[`PFM_FN_PERIODIC_TIMER_OUT_INV]);
    for (p = 4; p < 8; p = p + 1) begin
      ana(`PFM_PB+p, 2);
      ana(`PFM_PB+p, 3);
    end
    for (p = 0; p < 8; p = p + 1)
      ana(`PFM_PC+p, 2);
    for (p = 0; p < 7; p = p + 1) begin
      ana(`PFM_PD+p, 2);
      ana(`PFM_PD+p, 3);
    end
    for (p = 0; p < 4; p = p + 1)
      ana(`PFM_PE+p, 3);
    dig(`PFM_PE+3, 1, fn_out_i[`PFM_FN_STANDARD_TIMER_OUT_INV], fn_drv_i[`PFM_FN_STANDARD_TIMER_OUT_INV]);
    dig(`PFM_PE+2, 1, fn_out_i[`PFM_FN_STP], fn_drv_i[`PFM_FN_STP]);
    ana(`PFM_PE+1, 2);
    ana(`PFM_PE+2, 2);
    for (p = 4; p < 8; p = p + 1) begin
      ana(`PFM_PE+p, 2);
      ana(`PFM_PE+p, 3);
    end
    dig(`PFM_PE+6, 1, fn_out_i[`PFM_FN_COMPACT_TIMER1_OUT], fn_drv_i[`PFM_FN_COMPACT_TIMER1_OUT]);
    dig(`PFM_PE+7, 1, fn_out_i[`PFM_FN_COMPACT_TIMER1_OUT_INV], fn_drv_i[`PFM_FN_COMPACT_TIMER1_OUT_INV]);
    for (p = 0; p < 4; p = p + 1)
      ana(`PFM_PF+p, 3);
    dig(`PFM_PF+1, 1, fn_out_i[`PFM_FN_COMPACT_TIMER1_OUT], fn_drv_i[`PFM_FN_COMPACT_TIMER1_OUT]);
    dig(`PFM_PF+2, 1, fn_out_i[`PFM_FN_COMPACT_TIMER1_OUT_INV], fn_drv_i[`PFM_FN_COMPACT_TIMER1_OUT_INV]);
    dig(`PFM_PF+0, 2, fn_out_i[`PFM_FN_SCK], fn_drv_i[`PFM_FN_SCK]);
    dig(`PFM_PF+1, 2, fn_out_i[`PFM_FN_SDA], fn_drv_i[`PFM_FN_SDA]);
    dig(`PFM_PF+2, 2, fn_out_i[`PFM_FN_TX], fn_drv_i[`PFM_FN_TX]);
    dig(`PFM_PF+3, 2, fn_out_i[`PFM_FN_RX], fn_drv_i[`PFM_FN_RX]);
  end

  // ---------------- per pin output stage ----------------
  // pin index 31 has no pad; its field is the unimplemented pair
  generate
    for (g = 0; g < `PFM_NPIN; g = g + 1) begin : g_pin
      assign cd_w[2*g+:2] = sel_r[1+g/4][2*(g%4)+:2];
      pfm_pin_cell u_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .code_i(cd_w[2*g+:2]),
        .opt_out_i(fo[4*g+:4]),
        .opt_drv_i(fd[4*g+:4]),
        .opt_ana_i(fa[4*g+:4]),
        .pad_out_o(pad_out_o[g]),
        .pad_oe_n_o(pad_oe_n_o[g]),
        .pad_analog_o(pad_analog_o[g])
      );
    end
  endgenerate

  // ---------------- analog function enables ----------------
  always @* begin
    key_nxt = 24'h00_0000;
    seg_nxt = 24'h00_0000;
    an_nxt = 8'h00;
    for (n = 0; n < 4; n = n + 1) begin
      key_nxt[n] = cd_w[2*(`PFM_PB+4+n)+:2] == `PFM_CODE_ALT2;
      an_nxt[n] = cd_w[2*(`PFM_PB+n)+:2] == `PFM_CODE_ALT3;
      an_nxt[4+n] = cd_w[2*(`PFM_PB+4+n)+:2] == `PFM_CODE_ALT3;
      seg_nxt[8+n] = cd_w[2*(`PFM_PE+n)+:2] == `PFM_CODE_ALT3;
      key_nxt[20+n] = cd_w[2*(`PFM_PE+4+n)+:2] == `PFM_CODE_ALT2;
      seg_nxt[12+n] = cd_w[2*(`PFM_PE+4+n)+:2] == `PFM_CODE_ALT3;
      seg_nxt[20+n] = cd_w[2*(`PFM_PF+n)+:2] == `PFM_CODE_ALT3;
    end
    for (n = 0; n < 8; n = n + 1)
      key_nxt[4+n] = cd_w[2*(`PFM_PC+n)+:2] == `PFM_CODE_ALT2;
    for (n = 0; n < 7; n = n + 1) begin
      key_nxt[12+n] = cd_w[2*(`PFM_PD+n)+:2] == `PFM_CODE_ALT2;
      seg_nxt[n] = cd_w[2*(`PFM_PD+n)+:2] == `PFM_CODE_ALT3;
    end
    key_nxt[19] = cd_w[2*(`PFM_PA+7)+:2] == `PFM_CODE_ALT2;
    seg_nxt[7] = cd_w[2*(`PFM_PA+7)+:2] == `PFM_CODE_ALT3;
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      key_r <= 24'h00_0000;
      seg_r <= 24'h00_0000;
      an_r <= 8'h00;
      misc_r <= 8'h00;
    end else begin
      key_r <= key_nxt;
      seg_r <= seg_nxt;
      an_r <= an_nxt;
      misc_r[0] <= cd_w[2*(`PFM_PA+3)+:2] == `PFM_CODE_ALT2;
      misc_r[1] <= cd_w[2*(`PFM_PA+4)+:2] == `PFM_CODE_ALT2;
      misc_r[2] <= cd_w[2*(`PFM_PE+1)+:2] == `PFM_CODE_ALT2;
      misc_r[3] <= cd_w[2*(`PFM_PE+2)+:2] == `PFM_CODE_ALT2;
      misc_r[4] <= cd_w[2*(`PFM_PB+0)+:2] == `PFM_CODE_ALT2;
      misc_r[5] <= cd_w[2*(`PFM_PA+1)+:2] == `PFM_CODE_ALT3;
      misc_r[6] <= cd_w[2*(`PFM_PA+5)+:2] == `PFM_CODE_ALT3;
      misc_r[7] <= cd_w[2*(`PFM_PA+6)+:2] == `PFM_CODE_ALT3;
    end
  end

  assign touch_key_inputs_en_o = key_r;
  assign lcd_segment_outputs_en_o = seg_r;
  assign analog_channel_inputs_en_o = an_r;
  assign low_crystal_in_en_o = misc_r[0];
  assign low_crystal_out_en_o = misc_r[1];
  assign high_crystal_in_en_o = misc_r[2];
  assign high_crystal_out_en_o = misc_r[3];
  assign adc_vref_en_o = misc_r[4];
  assign lcd_bias_level_two_en_o = misc_r[5];
  assign lcd_pump_cap_first_en_o = misc_r[6];
  assign lcd_pump_cap_second_en_o = misc_r[7];

endmodule // pfm_pin_mux

// *** test/pfm_pin_mux_asserts.sv ***
module pfm_pin_mux_asserts (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins and port logic
  input wire [43:0] pad_out_o,
  input wire [43:0] pad_oe_n_o,
  input wire [43:0] pad_analog_o,
  input wire [43:0] gpio_out_i,
  input wire [43:0] gpio_drv_i,
  input wire [43:0] gpio_in_o,
  input wire [13:0] fn_out_i,
  input wire [13:0] fn_drv_i,
  // routed inputs and enables
  input wire serial_clock_in_o,
  input wire uart_rx_in_o,
  input wire spi_chip_select_in_o,
  input wire lcd_bias_level_two_en_o
);
  logic [7:0] ifs_r;
  logic [7:0] pa_lo_r;
  // shadows taken from the bus, so the routing is judged from the ports alone
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ifs_r <= 8'h00;
      pa_lo_r <= 8'h00;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h00) ifs_r <= {1'b0, wb_dat_i[6:0]};
      if (wb_adr_i == 8'h04) pa_lo_r <= wb_dat_i[7:0];
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_at(logic [7:0] a);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
  endsequence

  a_ack_next: assert property (s_take |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (wb_dat_o[31:8] == 24'h00_0000) else $error("upper read bits not zero");
  a_ifs_read: assert property (s_rd_at(8'h00) |=> wb_dat_o[7:0] == {1'b0, $past(ifs_r[6:0])})
    else $error("input source read wrong");
  a_pdh_read: assert property (s_rd_at(8'h20) |=> wb_dat_o[7:6] == 2'b00)
    else $error("port d high top bits not zero");
  a_sclk_route: assert property (serial_clock_in_o ==
    ($past(ifs_r[6]) ? $past(gpio_in_o[40]) : $past(gpio_in_o[9]))) else $error("serial clock source wrong");
  a_rx_route: assert property (uart_rx_in_o ==
    ($past(ifs_r[4]) ? $past(gpio_in_o[43]) : $past(gpio_in_o[11]))) else $error("uart receive source wrong");
  a_cs_route: assert property (spi_chip_select_in_o ==
    ($past(ifs_r[2]) ? $past(gpio_in_o[3]) : $past(gpio_in_o[2]))) else $error("chip select source wrong");
  a_pa0_data: assert property ($past(pa_lo_r[1:0]) == 2'b01 |->
    pad_out_o[0] == $past(fn_out_i[0]) && pad_oe_n_o[0] == !$past(fn_drv_i[0])) else $error("pa0 data out wrong");
  a_pa1_bias: assert property ($past(pa_lo_r[3:2]) == 2'b11 |->
    lcd_bias_level_two_en_o && pad_analog_o[1] && pad_oe_n_o[1]) else $error("pa1 bias wrong");
  a_pa2_gpio: assert property (!$past(rst_i) && $past(pa_lo_r[5:4]) != 2'b01 |->
    pad_out_o[2] == $past(gpio_out_i[2]) && pad_oe_n_o[2] == !$past(gpio_drv_i[2])) else $error("pa2 gpio wrong");
endmodule // pfm_pin_mux_asserts

bind pfm_pin_mux pfm_pin_mux_asserts u_asserts (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_out_o, .pad_oe_n_o, .pad_analog_o, .gpio_out_i, .gpio_drv_i,
  .gpio_in_o, .fn_out_i, .fn_drv_i, .serial_clock_in_o, .uart_rx_in_o, .spi_chip_select_in_o,
  .lcd_bias_level_two_en_o);

// *** test/pfm_pin_mux_tb_top.sv ***
`include "pfm_defs.vh"
module pfm_pin_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [43:0] pad_in_i = '0, gpio_out_i = '0, gpio_drv_i = '0;
  logic [13:0] fn_out_i = '0, fn_drv_i = '0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [43:0] pad_out_o, pad_oe_n_o, pad_analog_o, gpio_in_o;
  wire [11:0] rtd;
  wire [63:0] ens;
  int errors = 0, n_tests = 0, seed = 32'hb152, cyc_cnt = 0;
  int mreg [12];
  logic [7:0] q;

  pfm_pin_mux dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pad_analog_o(pad_analog_o),
    .gpio_out_i(gpio_out_i), .gpio_drv_i(gpio_drv_i), .gpio_in_o(gpio_in_o), .fn_out_i(fn_out_i),
    .fn_drv_i(fn_drv_i), .serial_clock_in_o(rtd[11]), .serial_data_in_line_o(rtd[10]), .uart_rx_in_o(rtd[9]),
    .compact_timer1_clock_in_o(rtd[8]), .spi_chip_select_in_o(rtd[7]), .periodic_timer_capture_in_o(rtd[6]),
    .standard_timer_capture_in_o(rtd[5]), .compact_timer0_clock_in_o(rtd[4]), .external_irq_zero_o(rtd[3]),
    .external_irq_one_o(rtd[2]), .periodic_timer_clock_in_o(rtd[1]), .standard_timer_clock_in_o(rtd[0]),
    .touch_key_inputs_en_o(ens[63:40]), .lcd_segment_outputs_en_o(ens[39:16]),
    .analog_channel_inputs_en_o(ens[15:8]), .low_crystal_in_en_o(ens[7]), .low_crystal_out_en_o(ens[6]),
    .high_crystal_in_en_o(ens[5]), .high_crystal_out_en_o(ens[4]), .adc_vref_en_o(ens[3]),
    .lcd_bias_level_two_en_o(ens[2]), .lcd_pump_cap_first_en_o(ens[1]), .lcd_pump_cap_second_en_o(ens[0])
  );

  always #5 mclk_i = ~mclk_i;

  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // about 1700 cycles are needed; a hung bus is cut off well beyond that
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t pin vector %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [7:0] msk(int i);
    return i == 0 ? `PFM_MASK_INPUT_SOURCE : i == 8 ? `PFM_MASK_PORTD_HIGH : `PFM_MASK_FULL;
  endfunction

  task automatic wr(int i, logic [7:0] d);
    fn_drv_i <= '0;
    wb(1'b1, 8'(4 * i), d, 4'h1);
    mreg[i] = d & msk(i);
  endtask

  // pin role for a code: peripheral index, -1 for port logic, -2 for analog
  function automatic int kind(int p, int c);
    if (c == 0) return -1;
    if (c == 2) begin
      if (p >= 40) return p - 38;
      if (p == 10) return 12;
      return (p inside {0, 1, 2, 5, 6, 9, 11, 31, 32, 35}) ? -1 : -2;
    end
    if (c == 3) return (p inside {0, 2, 3, 4, 31} || (p >= 16 && p < 24)) ? -1 : -2;
    case (p)
      0, 4: return 0;
      1: return 6;
      2, 3: return 1;
      5: return 7;
      8: return 3;
      9: return 2;
      10: return 4;
      11: return 5;
      12: return 13;
      34: return 10;
      35: return 11;
      38, 41: return 8;
      39, 42: return 9;
      default: return -1;
    endcase
  endfunction

  task automatic check_all();
    logic [43:0] eo, ee, ea, v;
    logic [7:0] f;
    int k;
    @(posedge mclk_i);
    pad_in_i <= {$random(seed), $random(seed)};
    gpio_out_i <= {$random(seed), $random(seed)};
    // timer clock, capture and interrupt input pins stay undriven by port logic
    gpio_drv_i <= {$random(seed), $random(seed)} & ~44'h12c_0000_f440;
    fn_out_i <= 14'($random(seed));
    fn_drv_i <= 14'($random(seed));
    repeat (7) @(posedge mclk_i);
    for (int p = 0; p < 44; p++) begin
      k = kind(p, (mreg[1 + p / 4] >> (2 * (p % 4))) & 3);
      ea[p] = k == -2;
      eo[p] = k >= 0 ? fn_out_i[k] : k == -1 && gpio_out_i[p];
      ee[p] = k >= 0 ? !fn_drv_i[k] : k == -2 || !gpio_drv_i[p];
    end
    chk_vec(pad_out_o & ~ea, eo);
    chk_vec(pad_oe_n_o, ee);
    chk_vec(pad_analog_o, ea);
    chk_vec(gpio_in_o, pad_in_i);
    v = pad_in_i;
    f = 8'(mreg[0]);
    chk_vec(rtd, {f[6] ? v[40] : v[9], f[5] ? v[41] : v[8], f[4] ? v[43] : v[11], f[3] ? v[40] : v[37],
      f[2] ? v[3] : v[2], f[1] ? v[12] : v[10], f[0] ? v[35] : v[34], v[6], v[6], v[15], v[14], v[13]});
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'(4 * i), 8'h00, 4'h1);
      chk_reg(q, 8'(mreg[i]));
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    chk_vec(pad_oe_n_o, {44{1'b1}});
    rst_i <= 1'b0;
    check_all();
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 12; i++) wr(i, {4{2'(c)}});
      check_all();
      chk_vec(ens, c == 2 ? {24'hff_ffff, 32'h0000_0000, 8'hf8} :
        c == 3 ? {24'h00_0000, 24'hf0_ffff, 16'hff07} : 64'h0);
    end
    repeat (16) begin
      for (int i = 0; i < 12; i++) wr(i, 8'($random(seed)));
      check_all();
    end
    // an unmapped place must read zero and a disabled byte lane must leave the register alone
    wb(1'b1, 8'h30, 8'h5a, 4'h1);
    wb(1'b0, 8'h30, 8'h00, 4'h1);
    chk_reg(q, 8'h00);
    wb(1'b1, 8'h04, ~8'(mreg[1]), 4'he);
    wb(1'b0, 8'h04, 8'h00, 4'h1);
    chk_reg(q, 8'(mreg[1]));
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (mreg[i]) mreg[i] = 0;
    check_all();
    print_verdict();
  end
endmodule // pfm_pin_mux_tb_top
